/* shared/ssbsa_map.svh */
// Offsets, field positions, reset values and fixed words of the clamp, bit-set and shift datapath.
`ifndef SSBSA_MAP_SVH
`define SSBSA_MAP_SVH
`define SSBSA_ADDR_WIDTH    4
`define SSBSA_STATUS_OFFSET 4'h0
`define SSBSA_STATUS_WIDTH  5
`define SSBSA_STATUS_RESET  5'h00
`define SSBSA_ZERO_BIT      0
`define SSBSA_SIGN_BIT      1
`define SSBSA_WRAP_BIT      2
`define SSBSA_CARRY_BIT     3
`define SSBSA_CLAMP_BIT     4
`define SSBSA_CLAMP_POS     32'h7FFFFFFF
`define SSBSA_CLAMP_NEG     32'h80000000
`define SSBSA_WORD_ONE      32'h00000001
`define SSBSA_WORD_ZERO     32'h00000000
`define SSBSA_BYTE_ONE      8'h01
`define SSBSA_COND_CLAMP    4'hD
`define SSBSA_COND_ALWAYS   4'h5
`endif

/* shared/ssbsa_pkg.sv */
// Types shared by the clamp, bit-set and shift datapath modules.
`include "ssbsa_map.svh"
package ssbsa_pkg;
  typedef enum logic [2:0] {
    SSBSA_OP_CLAMPED_REVERSE_SUBTRACT = 3'h0,
    SSBSA_OP_BIT_SET_RMW_DISP         = 3'h1,
    SSBSA_OP_BIT_SET_RMW_REG          = 3'h2,
    SSBSA_OP_CONDITION_TO_REGISTER    = 3'h3,
    SSBSA_OP_LOGICAL_LEFT_SHIFT       = 3'h4,
    SSBSA_OP_LOGICAL_RIGHT_SHIFT      = 3'h5
  } ssbsa_op_type;
  typedef enum logic [2:0] {
    SSBSA_COND_WRAP         = 3'h0,
    SSBSA_COND_CARRY        = 3'h1,
    SSBSA_COND_ZERO         = 3'h2,
    SSBSA_COND_CARRY_OR_ZERO = 3'h3,
    SSBSA_COND_SIGN         = 3'h4,
    SSBSA_COND_TRUE         = 3'h5,
    SSBSA_COND_LESS         = 3'h6,
    SSBSA_COND_LESS_EQUAL   = 3'h7
  } ssbsa_cond_type;
  typedef enum logic [1:0] {
    SSBSA_ST_IDLE   = 2'h0,
    SSBSA_ST_READ   = 2'h1,
    SSBSA_ST_MODIFY = 2'h3
  } ssbsa_fsm_type;
  typedef struct packed {
    ssbsa_fsm_type                    fsm;
    logic [`SSBSA_STATUS_WIDTH-1:0]   status;
    logic                             busy;
    logic                             rf_wr;
    logic [31:0]                      rf_wdata;
    logic                             mem_rd;
    logic                             mem_wr;
    logic [31:0]                      mem_addr;
    logic [7:0]                       mem_wdata;
    logic [2:0]                       bit_pos;
    logic [31:0]                      status_rdata;
  } ssbsa_regs_type;
endpackage

/* rtl/ssbsa_shifter.sv */
// Logical left and right word shifter with last-bit-out carry.
`timescale 1ns/1ps
module ssbsa_shifter (
  input  wire logic [31:0] value_i,
  input  wire logic [4:0]  count_i,
  input  wire logic        left_i,
  output logic      [31:0] result_o,
  output logic             carry_o
);
  logic [32:0] left_wide;
  logic [32:0] right_wide;

  // The spare bit catches the last bit shifted out and stays zero for a count of zero.
  assign left_wide  = {1'b0, value_i} << count_i;
  assign right_wide = {value_i, 1'b0} >> count_i;
  assign result_o   = left_i ? left_wide[31:0] : right_wide[32:1];
  assign carry_o    = left_i ? left_wide[32] : right_wide[0];
endmodule

/* rtl/ssbsa_cond_eval.sv */
// Evaluates a 4-bit condition code against the status flags.
`timescale 1ns/1ps
`include "ssbsa_map.svh"
module ssbsa_cond_eval
  import ssbsa_pkg::*;
(
  input  wire logic [3:0]                     cond_code_i,
  input  wire logic [`SSBSA_STATUS_WIDTH-1:0] status_i,
  output logic                                holds_o
);
  logic zero;
  logic sign;
  logic wrap;
  logic carry;
  logic base;

  assign zero  = status_i[`SSBSA_ZERO_BIT];
  assign sign  = status_i[`SSBSA_SIGN_BIT];
  assign wrap  = status_i[`SSBSA_WRAP_BIT];
  assign carry = status_i[`SSBSA_CARRY_BIT];

  always_comb begin
    unique case (cond_code_i[2:0])
      SSBSA_COND_WRAP:          base = wrap;
      SSBSA_COND_CARRY:         base = carry;
      SSBSA_COND_ZERO:          base = zero;
      SSBSA_COND_CARRY_OR_ZERO: base = carry | zero;
      SSBSA_COND_SIGN:          base = sign;
      SSBSA_COND_TRUE:          base = 1'b1;
      SSBSA_COND_LESS:          base = sign ^ wrap;
      SSBSA_COND_LESS_EQUAL:    base = (sign ^ wrap) | zero;
    endcase
    // The inverse of always-true is reused as the sticky clamp test.
    if (cond_code_i == `SSBSA_COND_CLAMP) begin
      holds_o = status_i[`SSBSA_CLAMP_BIT];
    end else begin
      holds_o = base ^ cond_code_i[3];
    end
  end
endmodule

/* rtl/ssbsa_alu.sv */
// Clamped reverse subtract, byte bit-set, condition-to-register and logical shift datapath.
//
// Operation
// - Reverse subtract writes source minus destination to destination; source untouched.
// - On overflow write 0x7FFFFFFF if positive, 0x80000000 if negative.
// - Subtract sets carry on borrow, wrap on overflow, sign and zero from result.
// - Clamp sticky flag sets on overflow, stays set, never alters execution.
// - Only a status word load clears the clamp sticky flag.
// - Displacement bit-set address is source plus sign-extended 16-bit displacement.
// - Bit-set reads byte, forces selected bit to one, writes it back.
// - Register bit-set uses source as address, destination low three bits as bit.
// - Bit-set loads zero flag with inverse of old bit; other flags kept.
// - Condition-to-register writes one if condition holds, else zero; flags kept.
// - Codes test wrap, carry, zero, sign, carry-or-zero; top bit inverts.
// - Code 0101 always, 1101 clamp, then sign xor wrap, with or zero.
// - Left shift by 0 to 31 from register or immediate, zero fill.
// - Right shift by 0 to 31 from register or immediate, zero fill.
// - Shifts load carry with last bit out, clear wrap, set sign and zero.
// - Zero count keeps the destination; count register is never written.
//
// The strobed register port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "ssbsa_map.svh"
module ssbsa_alu
  import ssbsa_pkg::*;
(
  input  wire logic                               clock_i,
  input  wire logic                               rst_n_i,
  input  wire logic                               op_valid_i,
  input  wire ssbsa_op_type                       op_i,
  input  wire logic [31:0]                        source_operand_register_i,
  input  wire logic [31:0]                        destination_operand_register_i,
  input  wire logic [4:0]                         five_bit_immediate_i,
  input  wire logic                               shift_use_immediate_i,
  input  wire logic [15:0]                        sixteen_bit_displacement_i,
  input  wire logic [2:0]                         bit_number_i,
  input  wire logic [3:0]                         cond_code_i,
  input  wire logic [`SSBSA_ADDR_WIDTH-1:0]       status_addr_i,
  input  wire logic                               system_register_load_i,
  input  wire logic [31:0]                        program_status_word_i,
  input  wire logic                               status_rd_i,
  input  wire logic [7:0]                         mem_rdata_i,
  output logic                                    busy_o,
  output logic                                    rf_wr_o,
  output logic [31:0]                             rf_wdata_o,
  output logic                                    mem_rd_o,
  output logic                                    mem_wr_o,
  output logic [31:0]                             mem_addr_o,
  output logic [7:0]                              mem_wdata_o,
  output logic [`SSBSA_STATUS_WIDTH-1:0]          program_status_word_o,
  output logic [31:0]                             status_rdata_o
);
  ssbsa_regs_type cur;
  ssbsa_regs_type nxt;

  logic        op_take;
  logic        status_hit;
  logic [32:0] sub_wide;
  logic        sub_borrow;
  logic        sub_wrap;
  logic [31:0] sub_result;
  logic [4:0]  shift_count;
  logic        shift_left;
  logic [31:0] shift_result;
  logic        shift_carry;
  logic        cond_holds;
  logic [31:0] disp_ext;
  logic        old_bit;

  // A new instruction is accepted only while no byte read-modify-write is in flight.
  assign op_take    = op_valid_i && (cur.fsm == SSBSA_ST_IDLE);
  assign status_hit = (status_addr_i == `SSBSA_STATUS_OFFSET);

  // Reverse subtract: the destination word is taken from the source word.
  assign sub_wide   = {1'b0, source_operand_register_i} - {1'b0, destination_operand_register_i};
  assign sub_borrow = sub_wide[32];
  assign sub_wrap   = (source_operand_register_i[31] != destination_operand_register_i[31]) &&
                      (sub_wide[31] != source_operand_register_i[31]);
  // A positive source can only overflow upward, a negative one only downward.
  assign sub_result = !sub_wrap ? sub_wide[31:0] :
                      (source_operand_register_i[31] ? `SSBSA_CLAMP_NEG : `SSBSA_CLAMP_POS);

  assign disp_ext = {{16{sixteen_bit_displacement_i[15]}}, sixteen_bit_displacement_i};

  assign shift_count = shift_use_immediate_i ? five_bit_immediate_i
                                             : source_operand_register_i[4:0];
  assign shift_left  = (op_i == SSBSA_OP_LOGICAL_LEFT_SHIFT);
  assign old_bit     = mem_rdata_i[cur.bit_pos];

  ssbsa_shifter u_shifter (
    .value_i  (destination_operand_register_i),
    .count_i  (shift_count),
    .left_i   (shift_left),
    .result_o (shift_result),
    .carry_o  (shift_carry)
  );

  // The evaluator sees the registered flags, which already hold the previous result.
  ssbsa_cond_eval u_cond_eval (
    .cond_code_i (cond_code_i),
    .status_i    (cur.status),
    .holds_o     (cond_holds)
  );

  always_comb begin
    nxt              = cur;
    nxt.rf_wr        = 1'b0;
    nxt.mem_rd       = 1'b0;
    nxt.mem_wr       = 1'b0;
    nxt.status_rdata = `SSBSA_WORD_ZERO;

    // Status readback shows the flags as they stand at the read edge.
    if (status_rd_i && status_hit) begin
      nxt.status_rdata = {27'h0000000, cur.status};
    end
    // A status load goes first; an instruction finishing in the same cycle then updates its own flags.
    if (system_register_load_i && status_hit) begin
      nxt.status = program_status_word_i[`SSBSA_STATUS_WIDTH-1:0];
    end

    unique case (cur.fsm)
      SSBSA_ST_IDLE: begin
        if (op_valid_i) begin
          unique case (op_i)
            SSBSA_OP_CLAMPED_REVERSE_SUBTRACT: begin
              nxt.rf_wr                     = 1'b1;
              nxt.rf_wdata                  = sub_result;
              nxt.status[`SSBSA_CARRY_BIT]  = sub_borrow;
              nxt.status[`SSBSA_WRAP_BIT]   = sub_wrap;
              nxt.status[`SSBSA_SIGN_BIT]   = sub_result[31];
              nxt.status[`SSBSA_ZERO_BIT]   = (sub_result == `SSBSA_WORD_ZERO);
              // Setting wins over a load of zero in the same cycle.
              if (sub_wrap) begin
                nxt.status[`SSBSA_CLAMP_BIT] = 1'b1;
              end
            end
            SSBSA_OP_BIT_SET_RMW_DISP: begin
              nxt.fsm      = SSBSA_ST_READ;
              nxt.busy     = 1'b1;
              nxt.mem_rd   = 1'b1;
              nxt.mem_addr = source_operand_register_i + disp_ext;
              nxt.bit_pos  = bit_number_i;
            end
            SSBSA_OP_BIT_SET_RMW_REG: begin
              nxt.fsm      = SSBSA_ST_READ;
              nxt.busy     = 1'b1;
              nxt.mem_rd   = 1'b1;
              nxt.mem_addr = source_operand_register_i;
              nxt.bit_pos  = destination_operand_register_i[2:0];
            end
            SSBSA_OP_CONDITION_TO_REGISTER: begin
              nxt.rf_wr    = 1'b1;
              nxt.rf_wdata = cond_holds ? `SSBSA_WORD_ONE : `SSBSA_WORD_ZERO;
            end
            SSBSA_OP_LOGICAL_LEFT_SHIFT,
            SSBSA_OP_LOGICAL_RIGHT_SHIFT: begin
              // A zero count passes the destination word through unchanged.
              nxt.rf_wr                    = 1'b1;
              nxt.rf_wdata                 = shift_result;
              nxt.status[`SSBSA_CARRY_BIT] = shift_carry;
              nxt.status[`SSBSA_WRAP_BIT]  = 1'b0;
              nxt.status[`SSBSA_SIGN_BIT]  = shift_result[31];
              nxt.status[`SSBSA_ZERO_BIT]  = (shift_result == `SSBSA_WORD_ZERO);
            end
            default: begin
              nxt.rf_wr = 1'b0;
            end
          endcase
        end
      end
      SSBSA_ST_READ: begin
        // The memory returns the byte in the cycle after the read strobe.
        nxt.fsm = SSBSA_ST_MODIFY;
      end
      SSBSA_ST_MODIFY: begin
        nxt.fsm                      = SSBSA_ST_IDLE;
        nxt.busy                     = 1'b0;
        nxt.mem_wr                   = 1'b1;
        nxt.mem_wdata                = mem_rdata_i | (`SSBSA_BYTE_ONE << cur.bit_pos);
        nxt.status[`SSBSA_ZERO_BIT]  = ~old_bit;
      end
      default: begin
        nxt.fsm  = SSBSA_ST_IDLE;
        nxt.busy = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      cur        <= '0;
      cur.status <= `SSBSA_STATUS_RESET;
    end else begin
      cur <= nxt;
    end
  end

  assign busy_o                = cur.busy;
  assign rf_wr_o               = cur.rf_wr;
  assign rf_wdata_o            = cur.rf_wdata;
  assign mem_rd_o              = cur.mem_rd;
  assign mem_wr_o              = cur.mem_wr;
  assign mem_addr_o            = cur.mem_addr;
  assign mem_wdata_o           = cur.mem_wdata;
  assign program_status_word_o = cur.status;
  assign status_rdata_o        = cur.status_rdata;

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);

  logic take_sub;
  logic take_bit_disp;
  logic take_bit_reg;
  logic take_cond;
  logic take_shift;

  assign take_sub      = op_take && (op_i == SSBSA_OP_CLAMPED_REVERSE_SUBTRACT);
  assign take_bit_disp = op_take && (op_i == SSBSA_OP_BIT_SET_RMW_DISP);
  assign take_bit_reg  = op_take && (op_i == SSBSA_OP_BIT_SET_RMW_REG);
  assign take_cond     = op_take && (op_i == SSBSA_OP_CONDITION_TO_REGISTER);
  assign take_shift    = op_take && ((op_i == SSBSA_OP_LOGICAL_LEFT_SHIFT) ||
                                     (op_i == SSBSA_OP_LOGICAL_RIGHT_SHIFT));

  // Read strobe, one quiet cycle, then write back to the same byte.
  sequence s_rmw_steps;
    mem_rd_o && !mem_wr_o && busy_o
    ##1 !mem_rd_o && !mem_wr_o && busy_o
    ##1 mem_wr_o && !mem_rd_o && !busy_o && $stable(mem_addr_o);
  endsequence

  property p_sub_plain;
    take_sub && !sub_wrap |=> rf_wr_o &&
      (rf_wdata_o == $past(source_operand_register_i) - $past(destination_operand_register_i));
  endproperty
  a_sub_plain: assert property (p_sub_plain) else $error("reverse subtract result wrong");

  property p_sub_clamp;
    take_sub && sub_wrap |=> rf_wr_o &&
      (rf_wdata_o == ($past(source_operand_register_i[31]) ? `SSBSA_CLAMP_NEG : `SSBSA_CLAMP_POS));
  endproperty
  a_sub_clamp: assert property (p_sub_clamp) else $error("clamped value wrong");

  property p_sub_flags;
    take_sub && !$past(system_register_load_i) |=>
      (program_status_word_o[`SSBSA_CARRY_BIT] ==
       ($past(source_operand_register_i) < $past(destination_operand_register_i))) &&
      (program_status_word_o[`SSBSA_SIGN_BIT] == rf_wdata_o[31]) &&
      (program_status_word_o[`SSBSA_ZERO_BIT] == (rf_wdata_o == `SSBSA_WORD_ZERO));
  endproperty
  a_sub_flags: assert property (p_sub_flags) else $error("subtract flags wrong");

  property p_clamp_sticky;
    program_status_word_o[`SSBSA_CLAMP_BIT] && !(system_register_load_i && status_hit)
      |=> program_status_word_o[`SSBSA_CLAMP_BIT];
  endproperty
  a_clamp_sticky: assert property (p_clamp_sticky) else $error("clamp flag dropped");

  property p_clamp_only_set_by_wrap;
    !program_status_word_o[`SSBSA_CLAMP_BIT] && !take_sub && !system_register_load_i
      |=> !program_status_word_o[`SSBSA_CLAMP_BIT];
  endproperty
  a_clamp_only_set_by_wrap: assert property (p_clamp_only_set_by_wrap) else $error("clamp set without cause");

  property p_bit_disp_flow;
    take_bit_disp |=>
      (mem_addr_o == $past(source_operand_register_i) +
                     {{16{$past(sixteen_bit_displacement_i[15])}}, $past(sixteen_bit_displacement_i)})
      ##0 s_rmw_steps;
  endproperty
  a_bit_disp_flow: assert property (p_bit_disp_flow) else $error("displacement bit-set flow wrong");

  property p_bit_reg_flow;
    take_bit_reg |=> (mem_addr_o == $past(source_operand_register_i)) ##0 s_rmw_steps;
  endproperty
  a_bit_reg_flow: assert property (p_bit_reg_flow) else $error("register bit-set flow wrong");

  property p_bit_forced;
    mem_wr_o |-> (mem_wdata_o == ($past(mem_rdata_i) | (`SSBSA_BYTE_ONE << cur.bit_pos)));
  endproperty
  a_bit_forced: assert property (p_bit_forced) else $error("written byte wrong");

  property p_bit_zero_flag;
    mem_wr_o && !$past(system_register_load_i) |->
      (program_status_word_o[`SSBSA_ZERO_BIT] == !$past(mem_rdata_i[cur.bit_pos])) &&
      (program_status_word_o[4:1] == $past(program_status_word_o[4:1]));
  endproperty
  a_bit_zero_flag: assert property (p_bit_zero_flag) else $error("bit-set flags wrong");

  property p_cond_write;
    take_cond && !system_register_load_i |=> rf_wr_o &&
      (rf_wdata_o == ($past(cond_holds) ? `SSBSA_WORD_ONE : `SSBSA_WORD_ZERO)) &&
      $stable(program_status_word_o);
  endproperty
  a_cond_write: assert property (p_cond_write) else $error("condition write wrong");

  property p_cond_always;
    take_cond && (cond_code_i == `SSBSA_COND_ALWAYS) |=> rf_wdata_o == `SSBSA_WORD_ONE;
  endproperty
  a_cond_always: assert property (p_cond_always) else $error("always condition failed");

  property p_cond_uses_prior_flags;
    take_cond && (cond_code_i == 4'h2) |=> rf_wdata_o[0] == $past(program_status_word_o[`SSBSA_ZERO_BIT]);
  endproperty
  a_cond_uses_prior_flags: assert property (p_cond_uses_prior_flags) else $error("condition flags stale");

  property p_shift_zero_count;
    take_shift && (shift_count == 5'h00) |=>
      (rf_wdata_o == $past(destination_operand_register_i)) && !program_status_word_o[`SSBSA_CARRY_BIT];
  endproperty
  a_shift_zero_count: assert property (p_shift_zero_count) else $error("zero-count shift wrong");

  property p_shift_value;
    take_shift |=> rf_wr_o && (rf_wdata_o == ($past(shift_left) ?
      ($past(destination_operand_register_i) << $past(shift_count)) :
      ($past(destination_operand_register_i) >> $past(shift_count))));
  endproperty
  a_shift_value: assert property (p_shift_value) else $error("shift result wrong");

  property p_shift_flags;
    take_shift |=> !program_status_word_o[`SSBSA_WRAP_BIT] &&
      (program_status_word_o[`SSBSA_SIGN_BIT] == rf_wdata_o[31]) &&
      (program_status_word_o[`SSBSA_ZERO_BIT] == (rf_wdata_o == `SSBSA_WORD_ZERO));
  endproperty
  a_shift_flags: assert property (p_shift_flags) else $error("shift flags wrong");

  property p_clamp_set;
    take_sub && sub_wrap |=> program_status_word_o[`SSBSA_CLAMP_BIT];
  endproperty
  a_clamp_set: assert property (p_clamp_set) else $error("clamp flag not set");

  property p_status_load;
    system_register_load_i && status_hit && !op_take && (cur.fsm != SSBSA_ST_MODIFY)
      |=> program_status_word_o == $past(program_status_word_i[`SSBSA_STATUS_WIDTH-1:0]);
  endproperty
  a_status_load: assert property (p_status_load) else $error("status load lost");

  property p_cond_clamp_code;
    take_cond && (cond_code_i == `SSBSA_COND_CLAMP) |=>
      rf_wdata_o[0] == $past(program_status_word_o[`SSBSA_CLAMP_BIT]);
  endproperty
  a_cond_clamp_code: assert property (p_cond_clamp_code) else $error("clamp condition wrong");

  property p_busy_refuses;
    busy_o |=> !rf_wr_o;
  endproperty
  a_busy_refuses: assert property (p_busy_refuses) else $error("request taken during bit-set");
endmodule

/* tb/ssbsa_mem_model.sv */
// Behavioural byte memory answering the datapath's read-modify-write cycles.
`timescale 1ns/1ps
module ssbsa_mem_model (
  input  wire logic        clock_i,
  input  wire logic        mem_rd_i,
  input  wire logic        mem_wr_i,
  input  wire logic [31:0] mem_addr_i,
  input  wire logic [7:0]  mem_wdata_i,
  output logic      [7:0]  mem_rdata_o
);
  logic [7:0] bytes_reg [16];
  initial begin
    for (int i = 0; i < 16; i++) begin
      bytes_reg[i] = 8'h5A ^ 8'(i);
    end
    mem_rdata_o = 8'h00;
  end
  // Outside the read slot the data flips every cycle, so a late sample never sees a stale byte.
  always @(posedge clock_i) begin
    mem_rdata_o <= mem_rd_i ? bytes_reg[mem_addr_i[3:0]] : ~mem_rdata_o;
    if (mem_wr_i) begin
      bytes_reg[mem_addr_i[3:0]] <= mem_wdata_i;
    end
  end
endmodule

/* tb/sat_sub_bitset_setflag_shift_alu_bench.sv */
// Self-checking bench for the clamp, bit-set, condition and shift datapath.
`timescale 1ns/1ps
module sat_sub_bitset_setflag_shift_alu_bench;
  import ssbsa_pkg::*;
  logic         clock_i, rst_n_i, op_valid_i, shift_use_immediate_i, system_register_load_i, status_rd_i;
  ssbsa_op_type op_i;
  logic [31:0]  src, dst, psw_in, rf_wdata_o, mem_addr_o, status_rdata_o;
  logic [4:0]   five_bit_immediate_i, program_status_word_o;
  logic [15:0]  sixteen_bit_displacement_i;
  logic [2:0]   bit_number_i;
  logic [3:0]   cond_code_i, status_addr_i;
  logic [7:0]   mem_rdata_i, mem_wdata_o;
  logic         busy_o, rf_wr_o, mem_rd_o, mem_wr_o;
  int           miscompares = 0;
  int           n_checks = 0;

  ssbsa_alu u_ssbsa_alu (.clock_i(clock_i), .rst_n_i(rst_n_i), .op_valid_i(op_valid_i), .op_i(op_i),
    .source_operand_register_i(src), .destination_operand_register_i(dst),
    .five_bit_immediate_i(five_bit_immediate_i), .shift_use_immediate_i(shift_use_immediate_i),
    .sixteen_bit_displacement_i(sixteen_bit_displacement_i), .bit_number_i(bit_number_i),
    .cond_code_i(cond_code_i), .status_addr_i(status_addr_i), .system_register_load_i(system_register_load_i),
    .program_status_word_i(psw_in), .status_rd_i(status_rd_i), .mem_rdata_i(mem_rdata_i), .busy_o(busy_o),
    .rf_wr_o(rf_wr_o), .rf_wdata_o(rf_wdata_o), .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o),
    .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .program_status_word_o(program_status_word_o),
    .status_rdata_o(status_rdata_o));
  ssbsa_mem_model u_ssbsa_mem_model (.clock_i(clock_i), .mem_rd_i(mem_rd_o), .mem_wr_i(mem_wr_o),
    .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o), .mem_rdata_o(mem_rdata_i));

  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Called just after a rising edge; the request stands for one cycle.
  task automatic drive(input ssbsa_op_type op, input logic [31:0] s, input logic [31:0] d);
    op_valid_i <= 1'b1;
    op_i       <= op;
    src        <= s;
    dst        <= d;
  endtask

  task automatic exec();
    @(posedge clock_i);
    op_valid_i <= 1'b0;
    #1;
  endtask

  task automatic wr_status(input logic [3:0] a, input logic [31:0] v);
    @(posedge clock_i);
    status_addr_i          <= a;
    psw_in                 <= v;
    system_register_load_i <= 1'b1;
    @(posedge clock_i);
    system_register_load_i <= 1'b0;
  endtask

  task automatic rd_status(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clock_i);
    status_addr_i <= a;
    status_rd_i   <= 1'b1;
    @(posedge clock_i);
    status_rd_i <= 1'b0;
    #1;
    check("status_rdata", status_rdata_o, exp);
  endtask

  function automatic logic cond_exp(input logic [3:0] c, input logic [4:0] f);
    logic r;
    case (c[2:0])
      3'h0: r = f[2];
      3'h1: r = f[3];
      3'h2: r = f[0];
      3'h3: r = f[3] | f[0];
      3'h4: r = f[1];
      3'h5: r = 1'b1;
      3'h6: r = f[1] ^ f[2];
      default: r = (f[1] ^ f[2]) | f[0];
    endcase
    return (c == 4'hD) ? f[4] : (c[3] ? ~r : r);
  endfunction

  task automatic test_subtract();
    logic [31:0] s [5];
    logic [31:0] d [5];
    logic [31:0] r [5];
    logic [4:0]  f [5];
    s = '{32'h00000005, 32'h00000003, 32'h7FFFFFFF, 32'h80000000, 32'h00000004};
    d = '{32'h00000003, 32'h00000005, 32'hFFFFFFFF, 32'h00000001, 32'h00000004};
    r = '{32'h00000002, 32'hFFFFFFFE, 32'h7FFFFFFF, 32'h80000000, 32'h00000000};
    f = '{5'h00, 5'h0A, 5'h1C, 5'h16, 5'h11};
    wr_status(4'h0, 32'h00000000);
    for (int i = 0; i < 5; i++) begin
      @(posedge clock_i);
      drive(SSBSA_OP_CLAMPED_REVERSE_SUBTRACT, s[i], d[i]);
      exec();
      check("sub_wr", rf_wr_o, 32'h00000001);
      check("sub_result", rf_wdata_o, r[i]);
      check("sub_flags", program_status_word_o, f[i]);
    end
    wr_status(4'h3, 32'h00000000);
    rd_status(4'h0, 32'h00000011);
    rd_status(4'h3, 32'h00000000);
    wr_status(4'h0, 32'hFFFFFFE0);
    rd_status(4'h0, 32'h00000000);
    @(posedge clock_i);
    system_register_load_i <= 1'b1;
    drive(SSBSA_OP_CLAMPED_REVERSE_SUBTRACT, s[3], d[3]);
    exec();
    system_register_load_i <= 1'b0;
    check("sub_load_same_edge", program_status_word_o, f[3]);
    $display("test subtract done");
  endtask

  task automatic test_shift();
    logic [31:0] d, r;
    logic        cy;
    int          n;
    d = 32'hC0000003;
    wr_status(4'h0, 32'h00000014);
    for (int k = 0; k < 64; k++) begin
      n  = k % 32;
      r  = (k < 32) ? d << n : d >> n;
      cy = (n == 0) ? 1'b0 : ((k < 32) ? d[32 - n] : d[n - 1]);
      @(posedge clock_i);
      shift_use_immediate_i <= k[0];
      five_bit_immediate_i  <= k[0] ? n[4:0] : ~n[4:0];
      drive((k < 32) ? SSBSA_OP_LOGICAL_LEFT_SHIFT : SSBSA_OP_LOGICAL_RIGHT_SHIFT,
            k[0] ? 32'hFFFFFFFF : {27'h7FFFFFF, n[4:0]}, d);
      exec();
      check("shift_result", rf_wdata_o, r);
      check("shift_flags", program_status_word_o, {27'h0, 1'b1, cy, 1'b0, r[31], r == 32'h0});
    end
    $display("test shift done");
  endtask

  task automatic test_condition();
    for (int f = 0; f < 32; f++) begin
      wr_status(4'h0, 32'(f));
      for (int c = 0; c < 16; c++) begin
        @(posedge clock_i);
        cond_code_i <= c[3:0];
        drive(SSBSA_OP_CONDITION_TO_REGISTER, 32'hFFFFFFFF, 32'hFFFFFFFF);
        exec();
        check("cond_result", rf_wdata_o, {31'h0, cond_exp(c[3:0], f[4:0])});
        check("cond_flags", program_status_word_o, 32'(f));
      end
    end
    wr_status(4'h0, 32'h00000000);
    @(posedge clock_i);
    drive(SSBSA_OP_CLAMPED_REVERSE_SUBTRACT, 32'h80000000, 32'h00000001);
    @(posedge clock_i);
    cond_code_i <= 4'h0;
    drive(SSBSA_OP_CONDITION_TO_REGISTER, 32'h0, 32'h0);
    exec();
    check("cond_after_sub", rf_wdata_o, 32'h00000001);
    $display("test condition done");
  endtask

  task automatic test_bit_set();
    logic [7:0]  b;
    logic [2:0]  bn;
    logic [31:0] ad;
    logic        z;
    b = 8'h52;
    wr_status(4'h0, 32'h0000001E);
    for (int k = 0; k < 9; k++) begin
      bn = (k < 8) ? k[2:0] : 3'h1;
      ad = (k < 8) ? 32'h000000F8 : 32'h00000203;
      if (k == 8) begin
        b = 8'h59;
      end
      z = ~b[bn];
      b[bn] = 1'b1;
      @(posedge clock_i);
      sixteen_bit_displacement_i <= 16'hFFF8;
      bit_number_i               <= k[2:0] ^ 3'(k / 8);
      drive((k < 8) ? SSBSA_OP_BIT_SET_RMW_DISP : SSBSA_OP_BIT_SET_RMW_REG,
            (k < 8) ? 32'h00000100 : ad, {29'h1FFFFFFF, bn});
      exec();
      check("bit_rd", {busy_o, mem_rd_o}, 32'h00000003);
      check("bit_addr", mem_addr_o, ad);
      @(posedge clock_i);
      drive(SSBSA_OP_CLAMPED_REVERSE_SUBTRACT, 32'h0, 32'h1);
      exec();
      check("bit_wr", {busy_o, rf_wr_o, mem_wr_o}, 32'h00000001);
      check("bit_data", mem_wdata_o, b);
      check("bit_flags", program_status_word_o, {28'hF, z});
    end
    $display("test bit set done");
  endtask

  initial begin
    {rst_n_i, op_valid_i, shift_use_immediate_i, system_register_load_i, status_rd_i} = 5'h00;
    {src, dst, psw_in} = 96'h0;
    {five_bit_immediate_i, sixteen_bit_displacement_i, bit_number_i, cond_code_i, status_addr_i} = 32'h0;
    op_i = SSBSA_OP_CLAMPED_REVERSE_SUBTRACT;
    repeat (16) @(posedge clock_i);
    rst_n_i <= 1'b1;
    @(posedge clock_i);
    #1;
    check("reset_flags", program_status_word_o, 32'h00000000);
    test_subtract();
    test_shift();
    test_condition();
    test_bit_set();
    finish_test();
  end

  initial begin
    repeat (100000) @(posedge clock_i);
    miscompares++;
    finish_test();
  end
endmodule
